// ---- eirq_ctrl.sv ----
`timescale 1ns/1ps
// External request flags and interrupt entry and return sequencing.
module eirq_ctrl
	import eirq_pkg::*;
(
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// External pins.
	input  wire logic [4:0]  ext_req_pin,
	input  wire logic [7:0]  wakeup_pin,
	// Processor core side.
	input  wire logic        insn_done,
	input  wire logic [15:0] core_pc,
	input  wire logic        return_from_exception,
	output logic             handler_start,
	output logic      [15:0] handler_pc,
	output logic      [7:0]  vector_num,
	output logic             rte_done,
	output logic      [15:0] restored_pc,
	// Memory port for stacking and fetch.
	output logic             mem_we,
	output logic             mem_re,
	output logic      [15:0] mem_addr,
	output logic      [15:0] mem_wdata,
	input  wire logic [15:0] mem_rdata,
	// Interrupt line.
	output logic             int_out
);
	// Software registers.
	logic [7:0]       pin_func_reg_one_r;
	logic [7:0]       pin_func_reg_three_r;
	logic [7:0]       pin_func_reg_five_r;
	logic [4:0]       edge_sense_reg_r;
	logic [7:0]       wakeup_edge_sel_r;
	logic [4:0]       request_flag_reg_one_r;
	logic [7:0]       wakeup_flag_reg_r;
	logic [15:0]      stack_pointer_r;
	logic [7:0]       cond_code_reg_r;
	logic [N_SRC-1:0] int_stat_r;
	logic [N_SRC-1:0] int_en_r;
	logic             pmr_acc_r;
	// Sequencer state.
	eirq_state_t      st_r;
	eirq_state_t      st_nxt;
	logic [3:0]       cnt_r;
	logic [3:0]       cnt_nxt;
	logic [15:0]      pc_save_r;
	// Output flops.
	logic [31:0]      prdata_r;
	logic             pready_r;
	logic             pslverr_r;
	logic             handler_start_r;
	logic [15:0]      handler_pc_r;
	logic [7:0]       vector_num_r;
	logic             rte_done_r;
	logic [15:0]      restored_pc_r;
	logic             mem_we_r;
	logic             mem_re_r;
	logic [15:0]      mem_addr_r;
	logic [15:0]      mem_wdata_r;
	logic             int_out_r;
	logic             mem_we_nxt;
	logic             mem_re_nxt;
	logic [15:0]      mem_addr_nxt;
	logic [15:0]      mem_wdata_nxt;

	// Pin events.
	logic [4:0] req_sel;
	logic [4:0] req_evt;
	logic [7:0] wake_evt;

	assign req_sel = {pin_func_reg_one_r[PFR1_LSB+3:PFR1_LSB],
	                  pin_func_reg_three_r[PFR3_BIT]};

	// One cell per pin; request pins and wakeup pins differ only in WAKE.
	genvar gi;
	generate
		for (gi = 0; gi < N_REQ; gi++) begin : g_req_cell
			eirq_edge_cell #(.WAKE(1'b0)) u_cell (
				.pclk     (pclk),
				.presetn  (presetn),
				.pin      (ext_req_pin[gi]),
				.sel      (req_sel[gi]),
				.rise_sel (edge_sense_reg_r[gi]),
				.evt      (req_evt[gi])
			);
		end
		for (gi = 0; gi < N_WAKE; gi++) begin : g_wake_cell
			eirq_edge_cell #(.WAKE(1'b1)) u_cell (
				.pclk     (pclk),
				.presetn  (presetn),
				.pin      (wakeup_pin[gi]),
				.sel      (pin_func_reg_five_r[gi]),
				.rise_sel (wakeup_edge_sel_r[gi]),
				.evt      (wake_evt[gi])
			);
		end
	endgenerate

	// APB decode; each access phase takes two cycles, pready rising in the second.
	logic acc;
	logic wr;
	logic first_acc;
	logic hit_pf1, hit_pf3, hit_pf5, hit_edge, hit_wedge, hit_rf1, hit_wf;
	logic hit_sp, hit_ccr, hit_stat, hit_en, hit_clr, hit_any, hit_pmr;
	assign first_acc = psel & penable & ~pready_r;
	assign acc       = psel & penable & pready_r;
	assign wr        = acc & pwrite;
	assign hit_pf1   = paddr == OFS_PIN_FUNC_ONE;
	assign hit_pf3   = paddr == OFS_PIN_FUNC_THREE;
	assign hit_pf5   = paddr == OFS_PIN_FUNC_FIVE;
	assign hit_edge  = paddr == OFS_EDGE_SENSE;
	assign hit_wedge = paddr == OFS_WAKEUP_EDGE;
	assign hit_rf1   = paddr == OFS_REQ_FLAG_ONE;
	assign hit_wf    = paddr == OFS_WAKEUP_FLAG;
	assign hit_sp    = paddr == OFS_STACK_POINTER;
	assign hit_ccr   = paddr == OFS_COND_CODE;
	assign hit_stat  = paddr == OFS_INT_STATUS;
	assign hit_en    = paddr == OFS_INT_ENABLE;
	assign hit_clr   = paddr == OFS_INT_CLEAR;
	assign hit_pmr   = hit_pf1 | hit_pf3 | hit_pf5;
	assign hit_any   = hit_pmr | hit_edge | hit_wedge | hit_rf1 | hit_wf | hit_sp
	                 | hit_ccr | hit_stat | hit_en | hit_clr;

	// Read mux; the clear register is write-only and reads zero.
	logic [31:0] rd_mux;
	assign rd_mux = hit_pf1   ? {24'h000000, pin_func_reg_one_r} :
	                hit_pf3   ? {24'h000000, pin_func_reg_three_r} :
	                hit_pf5   ? {24'h000000, pin_func_reg_five_r} :
	                hit_edge  ? {27'h0000000, edge_sense_reg_r} :
	                hit_wedge ? {24'h000000, wakeup_edge_sel_r} :
	                hit_rf1   ? {27'h0000000, request_flag_reg_one_r} :
	                hit_wf    ? {24'h000000, wakeup_flag_reg_r} :
	                hit_sp    ? {16'h0000, stack_pointer_r} :
	                hit_ccr   ? {24'h000000, cond_code_reg_r} :
	                hit_stat  ? {19'h00000, int_stat_r} :
	                hit_en    ? {19'h00000, int_en_r} : 32'h00000000;

	// A request or wakeup flag clear written right after a pin function access is dropped; set beats clear.
	logic [4:0]       req_clr;
	logic [7:0]       wake_clr;
	logic [N_SRC-1:0] stat_clr;
	logic             clr_blocked;
	assign clr_blocked = pmr_acc_r;
	assign req_clr  = (wr & hit_rf1 & ~clr_blocked) ? ~pwdata[4:0] : 5'h00;
	assign wake_clr = (wr & hit_wf & ~clr_blocked) ? ~pwdata[7:0] : 8'h00;
	assign stat_clr = (wr & hit_clr) ? pwdata[N_SRC-1:0] : 13'h0000;

	// Pending requests and priority: pin 0 first, the shared wakeup vector last.
	logic [4:0] req_pend;
	logic       wake_pend;
	logic       any_pend;
	logic [7:0] vec_sel;
	assign req_pend  = request_flag_reg_one_r & int_en_r[N_REQ-1:0];
	assign wake_pend = |(wakeup_flag_reg_r & int_en_r[N_SRC-1:N_REQ]);
	assign any_pend  = (|req_pend | wake_pend) & ~cond_code_reg_r[CCR_I_BIT];
	assign vec_sel = req_pend[0] ? VEC_REQ0 :
	                 req_pend[1] ? VEC_REQ0 + 8'h01 :
	                 req_pend[2] ? VEC_REQ0 + 8'h02 :
	                 req_pend[3] ? VEC_REQ0 + 8'h03 :
	                 req_pend[4] ? VEC_REQ0 + 8'h04 : VEC_WAKE;

	// Phase ends and word-aligned addresses.
	logic        stack_end, int_end, rte_end;
	logic [15:0] sp_pc_addr, sp_ccr_addr, vec_addr, rte_pc_addr;
	assign stack_end   = (st_r == ST_STACK) && (cnt_r == STACK_ST - 4'h1);
	assign int_end     = (st_r == ST_INTERNAL) && (cnt_r == INTERNAL_ST - 4'h1);
	assign rte_end     = (st_r == ST_RTE) && (cnt_r == RTE_ST - 4'h1);
	assign sp_pc_addr  = stack_pointer_r - WORD_STEP;
	assign sp_ccr_addr = stack_pointer_r - FRAME_STEP;
	assign vec_addr    = {7'h00, vector_num_r, 1'b0};
	assign rte_pc_addr = stack_pointer_r + WORD_STEP;

	// Entry waits for the instruction, but never past the longest instruction.
	always_comb begin
		st_nxt  = st_r;
		cnt_nxt = cnt_r + 4'h1;
		case (st_r)
			ST_IDLE: begin
				cnt_nxt = 4'h0;
				if (return_from_exception) begin
					st_nxt = ST_RTE;
				end else if (any_pend) begin
					st_nxt  = ST_WAIT;
					cnt_nxt = 4'h1;
				end
			end
			ST_WAIT: if (insn_done || cnt_r == WAIT_MAX) begin
				st_nxt  = ST_STACK;
				cnt_nxt = 4'h0;
			end
			ST_STACK: if (stack_end) begin
				st_nxt  = ST_VEC;
				cnt_nxt = 4'h0;
			end
			ST_VEC: if (cnt_r == VEC_ST - 4'h1) begin
				st_nxt  = ST_IFETCH;
				cnt_nxt = 4'h0;
			end
			ST_IFETCH: if (cnt_r == IFETCH_ST - 4'h1) begin
				st_nxt  = ST_INTERNAL;
				cnt_nxt = 4'h0;
			end
			ST_INTERNAL: if (int_end) begin
				st_nxt  = ST_IDLE;
				cnt_nxt = 4'h0;
			end
			ST_RTE: if (rte_end) begin
				st_nxt  = ST_IDLE;
				cnt_nxt = 4'h0;
			end
			default: begin
				st_nxt  = ST_IDLE;
				cnt_nxt = 4'h0;
			end
		endcase
	end

	// Memory requests; bit zero is always cleared because every access is a word.
	logic stk_pc, stk_ccr, rd_vec, rd_fetch, rd_rte0, rd_rte1;
	assign stk_pc   = (st_r == ST_STACK) && (cnt_r == 4'h0);
	assign stk_ccr  = (st_r == ST_STACK) && (cnt_r == 4'h2);
	assign rd_vec   = (st_r == ST_VEC) && (cnt_r == 4'h0);
	assign rd_fetch = (st_r == ST_IFETCH) && (cnt_r == 4'h0);
	assign rd_rte0  = (st_r == ST_RTE) && (cnt_r == 4'h0);
	assign rd_rte1  = (st_r == ST_RTE) && (cnt_r == 4'h1);
	assign mem_we_nxt = stk_pc | stk_ccr;
	assign mem_re_nxt = rd_vec | rd_fetch | rd_rte0 | rd_rte1;
	assign mem_addr_nxt = {(stk_pc   ? sp_pc_addr[15:1] :
	                        stk_ccr  ? sp_ccr_addr[15:1] :
	                        rd_vec   ? vec_addr[15:1] :
	                        rd_fetch ? handler_pc_r[15:1] :
	                        rd_rte1  ? rte_pc_addr[15:1] : stack_pointer_r[15:1]), 1'b0};
	assign mem_wdata_nxt = stk_ccr ? {cond_code_reg_r, cond_code_reg_r} : pc_save_r;

	// Captures from memory: each read answers in the cycle its strobe is high.
	logic        cap_vec, cap_ccr, cap_pc;
	logic [7:0]  rd_even_byte;
	logic [15:0] sp_nxt;
	logic [7:0]  ccr_nxt;
	assign cap_vec      = (st_r == ST_VEC) && (cnt_r == 4'h1);
	assign cap_ccr      = (st_r == ST_RTE) && (cnt_r == 4'h1);
	assign cap_pc       = (st_r == ST_RTE) && (cnt_r == 4'h2);
	assign rd_even_byte = mem_rdata[15:8];
	assign sp_nxt = stack_end ? sp_ccr_addr :
	                rte_end ? stack_pointer_r + FRAME_STEP :
	                (wr & hit_sp) ? pwdata[15:0] : stack_pointer_r;
	assign ccr_nxt = cap_ccr ? rd_even_byte :
	                 int_end ? (cond_code_reg_r | (8'h01 << CCR_I_BIT)) :
	                 (wr & hit_ccr) ? pwdata[7:0] : cond_code_reg_r;

	// Configuration registers, all selects clear at reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_func_reg_one_r   <= 8'h00;
			pin_func_reg_three_r <= 8'h00;
			pin_func_reg_five_r  <= 8'h00;
			edge_sense_reg_r     <= 5'h00;
			wakeup_edge_sel_r    <= 8'h00;
			int_en_r             <= 13'h0000;
		end else begin
			if (wr & hit_pf1) pin_func_reg_one_r <= pwdata[7:0];
			if (wr & hit_pf3) pin_func_reg_three_r <= pwdata[7:0];
			if (wr & hit_pf5) pin_func_reg_five_r <= pwdata[7:0];
			if (wr & hit_edge) edge_sense_reg_r <= pwdata[4:0];
			if (wr & hit_wedge) wakeup_edge_sel_r <= pwdata[7:0];
			if (wr & hit_en) int_en_r <= pwdata[N_SRC-1:0];
		end
	end

	// Flags and status; acceptance of a request never clears them.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			request_flag_reg_one_r <= 5'h00;
			wakeup_flag_reg_r      <= 8'h00;
			int_stat_r             <= 13'h0000;
			pmr_acc_r              <= 1'b0;
			int_out_r              <= 1'b0;
		end else begin
			request_flag_reg_one_r <= (request_flag_reg_one_r & ~req_clr) | req_evt;
			wakeup_flag_reg_r      <= (wakeup_flag_reg_r & ~wake_clr) | wake_evt;
			int_stat_r <= (int_stat_r & ~stat_clr) | {wake_evt, req_evt};
			if (acc) pmr_acc_r <= hit_pmr;
			int_out_r <= |(int_stat_r & int_en_r);
		end
	end

	// Sequencer, stack and condition code registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r            <= ST_IDLE;
			cnt_r           <= 4'h0;
			stack_pointer_r <= SP_RST;
			cond_code_reg_r <= CCR_RST;
			pc_save_r       <= 16'h0000;
			vector_num_r    <= 8'h00;
		end else begin
			st_r            <= st_nxt;
			cnt_r           <= cnt_nxt;
			stack_pointer_r <= sp_nxt;
			cond_code_reg_r <= ccr_nxt;
			if (st_r == ST_WAIT && st_nxt == ST_STACK) pc_save_r <= core_pc;
			if (st_r == ST_IDLE && st_nxt == ST_WAIT) vector_num_r <= vec_sel;
		end
	end

	// Registered outputs toward the bus, core and memory.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r        <= 32'h00000000;
			pready_r        <= 1'b0;
			pslverr_r       <= 1'b0;
			handler_start_r <= 1'b0;
			handler_pc_r    <= 16'h0000;
			rte_done_r      <= 1'b0;
			restored_pc_r   <= 16'h0000;
			mem_we_r        <= 1'b0;
			mem_re_r        <= 1'b0;
			mem_addr_r      <= 16'h0000;
			mem_wdata_r     <= 16'h0000;
		end else begin
			pready_r        <= first_acc;
			pslverr_r       <= first_acc & ~hit_any;
			if (first_acc) prdata_r <= rd_mux;
			handler_start_r <= int_end;
			if (cap_vec) handler_pc_r <= mem_rdata;
			rte_done_r      <= rte_end;
			if (cap_pc) restored_pc_r <= mem_rdata;
			mem_we_r        <= mem_we_nxt;
			mem_re_r        <= mem_re_nxt;
			mem_addr_r      <= mem_addr_nxt;
			mem_wdata_r     <= mem_wdata_nxt;
		end
	end

	assign prdata        = prdata_r;
	assign pready        = pready_r;
	assign pslverr       = pslverr_r;
	assign handler_start = handler_start_r;
	assign handler_pc    = handler_pc_r;
	assign vector_num    = vector_num_r;
	assign rte_done      = rte_done_r;
	assign restored_pc   = restored_pc_r;
	assign mem_we        = mem_we_r;
	assign mem_re        = mem_re_r;
	assign mem_addr      = mem_addr_r;
	assign mem_wdata     = mem_wdata_r;
	assign int_out       = int_out_r;

	// Checks on phase lengths, alignment and flag behaviour.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic in_wait, in_stack, in_vec, in_fetch, in_int;
	assign in_wait  = st_r == ST_WAIT;
	assign in_stack = st_r == ST_STACK;
	assign in_vec   = st_r == ST_VEC;
	assign in_fetch = st_r == ST_IFETCH;
	assign in_int   = st_r == ST_INTERNAL;

	a_wait_bound: assert property ($rose(in_wait) |-> ##[1:13] in_stack)
		else $error("instruction wait exceeded its bound");
	a_entry_total: assert property ($rose(in_wait) |-> ##[15:27] handler_start)
		else $error("handler start outside latency window");
	a_stack_len: assert property ($rose(in_stack) |-> in_stack[*4] ##1 in_vec)
		else $error("stacking phase length wrong");
	a_vec_fetch: assert property ($rose(in_vec) |-> in_vec[*2] ##1 in_fetch[*4] ##1 in_int)
		else $error("vector or fetch phase length wrong");
	a_internal_len: assert property ($rose(in_int) |-> in_int[*4] ##1 handler_start)
		else $error("internal phase length wrong");
	a_word_even: assert property ((mem_we || mem_re) |-> !mem_addr[0])
		else $error("odd word address driven");
	a_ccr_word: assert property ($rose(in_stack) |-> ##3 mem_we
		&& mem_wdata == {cond_code_reg_r, cond_code_reg_r})
		else $error("condition codes not stacked as a word");
	a_rte_even: assert property (cap_ccr |=> cond_code_reg_r == $past(rd_even_byte))
		else $error("return did not load even byte");
	a_sel_rise: assert property (($rose(pin_func_reg_one_r[1]) && !ext_req_pin[1]
		&& !edge_sense_reg_r[1]) |=> request_flag_reg_one_r[1])
		else $error("select rise on low pin did not set flag");
	a_sel_fall: assert property (($fell(pin_func_reg_one_r[2]) && !ext_req_pin[2]
		&& edge_sense_reg_r[2]) |=> request_flag_reg_one_r[2])
		else $error("select fall on low pin did not set flag");
	a_wake_sel: assert property (($rose(pin_func_reg_five_r[0]) && !wakeup_pin[0])
		|=> wakeup_flag_reg_r[0])
		else $error("wakeup select on low pin did not set flag");
	a_clear_blocked: assert property ((wr && (hit_rf1 || hit_wf) && pmr_acc_r)
		|=> ((request_flag_reg_one_r & $past(request_flag_reg_one_r))
		== $past(request_flag_reg_one_r))
		&& ((wakeup_flag_reg_r & $past(wakeup_flag_reg_r)) == $past(wakeup_flag_reg_r)))
		else $error("flag cleared right after pin function access");
	a_wake_sticky: assert property ((wakeup_flag_reg_r[0] && !(wr && hit_wf))
		|=> wakeup_flag_reg_r[0])
		else $error("wakeup flag cleared without a write");

	c_entry: cover property ($rose(in_wait) ##[15:27] handler_start);
	c_return: cover property (rte_done);
	c_blocked: cover property (wr && hit_rf1 && pmr_acc_r && |request_flag_reg_one_r);

endmodule : eirq_ctrl

// ---- eirq_pkg.sv ----
package eirq_pkg;

	// Register byte offsets on the APB.
	localparam logic [7:0] OFS_PIN_FUNC_ONE   = 8'h00;
	localparam logic [7:0] OFS_PIN_FUNC_THREE = 8'h04;
	localparam logic [7:0] OFS_PIN_FUNC_FIVE  = 8'h08;
	localparam logic [7:0] OFS_EDGE_SENSE     = 8'h0c;
	localparam logic [7:0] OFS_WAKEUP_EDGE    = 8'h10;
	localparam logic [7:0] OFS_REQ_FLAG_ONE   = 8'h14;
	localparam logic [7:0] OFS_WAKEUP_FLAG    = 8'h18;
	localparam logic [7:0] OFS_STACK_POINTER  = 8'h1c;
	localparam logic [7:0] OFS_COND_CODE      = 8'h20;
	localparam logic [7:0] OFS_INT_STATUS     = 8'h24;
	localparam logic [7:0] OFS_INT_ENABLE     = 8'h28;
	localparam logic [7:0] OFS_INT_CLEAR      = 8'h2c;

	// Source counts and field positions.
	localparam int N_REQ  = 5;
	localparam int N_WAKE = 8;
	localparam int N_SRC  = 13;
	localparam int PFR1_LSB = 1;
	localparam int PFR3_BIT = 0;
	localparam int CCR_I_BIT = 7;

	// Reset values.
	localparam logic [7:0]  CCR_RST = 8'h80;
	localparam logic [15:0] SP_RST  = 16'h0000;

	// Phase lengths in states; one state is one pclk cycle.
	localparam logic [3:0] WAIT_MAX    = 4'hd;
	localparam logic [3:0] STACK_ST    = 4'h4;
	localparam logic [3:0] VEC_ST      = 4'h2;
	localparam logic [3:0] IFETCH_ST   = 4'h4;
	localparam logic [3:0] INTERNAL_ST = 4'h4;
	localparam logic [3:0] RTE_ST      = 4'h4;

	// Vector numbers and stack word step.
	localparam logic [7:0]  VEC_REQ0 = 8'h04;
	localparam logic [7:0]  VEC_WAKE = 8'h09;
	localparam logic [15:0] WORD_STEP = 16'h0002;
	localparam logic [15:0] FRAME_STEP = 16'h0004;

	typedef enum logic [2:0] {
		ST_IDLE, ST_WAIT, ST_STACK, ST_VEC, ST_IFETCH, ST_INTERNAL, ST_RTE
	} eirq_state_t;

endpackage : eirq_pkg

// ---- eirq_edge_cell.sv ----
`timescale 1ns/1ps
// One pin's edge sensing; emits a one-cycle event.
module eirq_edge_cell
	import eirq_pkg::*;
#(
	parameter bit WAKE = 1'b0
) (
	// Clock and reset.
	input  wire logic pclk,
	input  wire logic presetn,
	// Pin and its controls.
	input  wire logic pin,
	input  wire logic sel,
	input  wire logic rise_sel,
	// Event out.
	output logic      evt
);
	logic gated;
	logic gated_r;
	logic pin_r;
	logic sel_r;

	// A deselected pin reads as high, so select changes on a low pin look like edges.
	assign gated = sel ? pin : 1'b1;

	// Previous values start high and deselected, so reset never makes an event.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gated_r <= 1'b1;
			pin_r   <= 1'b1;
			sel_r   <= 1'b0;
		end else begin
			gated_r <= gated;
			pin_r   <= pin;
			sel_r   <= sel;
		end
	end

	// Request pins see both select directions; wakeup pins only a fresh select.
	generate
		if (WAKE) begin : g_wake
			logic pin_edge;
			assign pin_edge = rise_sel ? (pin & ~pin_r) : (~pin & pin_r);
			assign evt = sel & (sel_r ? pin_edge : ~pin);
		end else begin : g_req
			assign evt = rise_sel ? (gated & ~gated_r) : (~gated & gated_r);
		end
	endgenerate

endmodule : eirq_edge_cell

// ---- eirq_core_model.sv ----
`timescale 1ns/1ps
// Stand-in for the core and its memory: answers reads in the strobe cycle.
module eirq_core_model
	import eirq_pkg::*;
#(
	parameter logic [15:0] RET_PC = 16'h0246
) (
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Core handshake.
	output logic             insn_done,
	output logic      [15:0] core_pc,
	// Memory port.
	input  wire logic        mem_we,
	input  wire logic        mem_re,
	input  wire logic [15:0] mem_addr,
	input  wire logic [15:0] mem_wdata,
	output logic      [15:0] mem_rdata,
	// Flag for an odd word address.
	output logic             odd_seen
);
	logic [15:0] mem [0:255];
	logic [2:0]  cnt_r;

	// Outside a read the data moves every cycle, so stale data never matches.
	assign mem_rdata = mem_re ? mem[mem_addr[8:1]] : {13'h0000, cnt_r} ^ 16'ha5a5;
	assign core_pc   = RET_PC;
	assign insn_done = (cnt_r == 3'h0); // An instruction ends every eighth state.

	// Word stores land in the array; the bench also preloads it.
	always @(posedge pclk) begin
		if (mem_we) begin
			mem[mem_addr[8:1]] <= mem_wdata;
		end
	end

	// State counter and odd address watch.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r    <= 3'h1;
			odd_seen <= 1'b0;
		end else begin
			cnt_r <= cnt_r + 3'h1;
			if ((mem_we | mem_re) & mem_addr[0]) begin
				odd_seen <= 1'b1;
			end
		end
	end
endmodule : eirq_core_model

// ---- tb_top.sv ----
`timescale 1ns/1ps
// Drives the block over APB and its pins, and checks flags and entry.
module tb_top;
	import eirq_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0]  paddr, wakeup_pin, vector_num;
	logic [31:0] pwdata, prdata, q;
	logic [4:0]  ext_req_pin;
	logic        insn_done, return_from_exception, handler_start, rte_done;
	logic        mem_we, mem_re, int_out, odd_seen;
	logic [15:0] core_pc, handler_pc, restored_pc, mem_addr, mem_wdata, mem_rdata;
	int          num_errors, tests_run, n;

	eirq_ctrl i_eirq_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .ext_req_pin, .wakeup_pin, .insn_done, .core_pc,
		.return_from_exception, .handler_start, .handler_pc, .vector_num, .rte_done,
		.restored_pc, .mem_we, .mem_re, .mem_addr, .mem_wdata, .mem_rdata, .int_out);
	eirq_core_model i_eirq_core_model (.pclk, .presetn, .insn_done, .core_pc, .mem_we,
		.mem_re, .mem_addr, .mem_wdata, .mem_rdata, .odd_seen);

	// Free running 100 MHz clock.
	always #5 pclk = ~pclk;

	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// One APB transfer, held until pready, then one idle cycle.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		chk("pready", 32'h1, {31'h0, pready});
		if (pready !== 1'b1) end_of_test();
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, exp, q);
	endtask : rd

	// Main sequence.
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ext_req_pin = 5'h1f; // Pins rest high unless a test pulls them.
		wakeup_pin = 8'hff;
		return_from_exception = 1'b0;
		num_errors = 0;
		tests_run = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd("cond_code_reg", OFS_COND_CODE, 32'h80);
		apb(1'b0, 8'h30, 32'h0);
		chk("pslverr", 32'h1, {31'h0, e});
		$display("Test reset done");
		wakeup_pin <= 8'hfe;
		apb(1'b1, OFS_PIN_FUNC_FIVE, 32'h1);
		apb(1'b1, OFS_WAKEUP_FLAG, 32'h0);
		rd("wakeup_flag_reg", OFS_WAKEUP_FLAG, 32'h1);
		apb(1'b1, OFS_WAKEUP_FLAG, 32'hff);
		rd("wakeup_flag_reg", OFS_WAKEUP_FLAG, 32'h1);
		rd("int_status", OFS_INT_STATUS, 32'h20);
		apb(1'b1, OFS_INT_ENABLE, 32'h20);
		@(negedge pclk);
		chk("int_out", 32'h1, {31'h0, int_out});
		@(posedge pclk);
		apb(1'b1, OFS_INT_CLEAR, 32'h20);
		@(negedge pclk);
		chk("int_out", 32'h0, {31'h0, int_out});
		@(posedge pclk);
		apb(1'b1, OFS_WAKEUP_FLAG, 32'h0);
		rd("wakeup_flag_reg", OFS_WAKEUP_FLAG, 32'h0);
		$display("Test wakeup done");
		apb(1'b1, OFS_WAKEUP_EDGE, 32'h2);
		apb(1'b1, OFS_PIN_FUNC_FIVE, 32'h3);
		wakeup_pin <= 8'hfc;
		repeat (3) @(posedge pclk);
		rd("wakeup_flag_reg", OFS_WAKEUP_FLAG, 32'h0);
		wakeup_pin <= 8'hfe;
		repeat (3) @(posedge pclk);
		rd("wakeup_flag_reg", OFS_WAKEUP_FLAG, 32'h2);
		ext_req_pin <= 5'h19;
		apb(1'b1, OFS_EDGE_SENSE, 32'h4);
		apb(1'b1, OFS_PIN_FUNC_ONE, 32'h6);
		apb(1'b1, OFS_PIN_FUNC_ONE, 32'h2);
		apb(1'b1, OFS_REQ_FLAG_ONE, 32'h0);
		rd("request_flag_reg_one", OFS_REQ_FLAG_ONE, 32'h6);
		$display("Test request pins done");
		i_eirq_core_model.mem[4] = 16'h00c0;
		apb(1'b1, OFS_INT_ENABLE, 32'h1);
		apb(1'b1, OFS_STACK_POINTER, 32'h100); // Even pointer only.
		apb(1'b1, OFS_COND_CODE, 32'h05);
		ext_req_pin <= 5'h18;
		apb(1'b1, OFS_PIN_FUNC_THREE, 32'h1);
		n = 1;
		while (handler_start !== 1'b1 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		chk("entry_latency", 32'h1, {31'h0, n >= 15 && n <= 29});
		chk("vector_num", 32'h4, {24'h0, vector_num});
		chk("handler_pc", 32'hc0, {16'h0, handler_pc});
		chk("pc_word", 32'h0246, {16'h0, i_eirq_core_model.mem[8'h7f]});
		chk("ccr_word", 32'h0505, {16'h0, i_eirq_core_model.mem[8'h7e]});
		chk("odd_seen", 32'h0, {31'h0, odd_seen});
		rd("stack_pointer", OFS_STACK_POINTER, 32'hfc);
		rd("cond_code_reg", OFS_COND_CODE, 32'h85);
		rd("request_flag_reg_one", OFS_REQ_FLAG_ONE, 32'h7);
		$display("Test entry done");
		i_eirq_core_model.mem[8'h7e] = 16'h92ab;
		return_from_exception <= 1'b1;
		@(posedge pclk);
		return_from_exception <= 1'b0;
		n = 0;
		while (rte_done !== 1'b1 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		chk("rte_done", 32'h1, {31'h0, rte_done});
		chk("restored_pc", 32'h0246, {16'h0, restored_pc});
		rd("cond_code_reg", OFS_COND_CODE, 32'h92);
		rd("stack_pointer", OFS_STACK_POINTER, 32'h100);
		$display("Test return done");
		end_of_test();
	end
endmodule : tb_top
